// ### design/pifb_defs.svh
// Functional notes
// RULE_01 - timer zero overflow sets bank 0 bit 5 until software clears.
// RULE_02 - bank 0 bit 4 is read-only OR of all per-pin change flags.
// RULE_03 - bank 0 bits 0..2 set on selected edge of each external input.
// RULE_04 - bank 0 requests bypass the peripheral gate.
// RULE_05 - each external input pin is chosen by the pin-select register.
// RULE_06 - oscillator failure sets bank 1 bit 7; software clears it.
// RULE_07 - new oscillator ready sets bank 1 bit 6; software clears it.
// RULE_08 - clock switch ready flag never wakes the core from sleep.
// RULE_09 - ADC threshold event sets bank 1 bit 1 until software clears.
// RULE_10 - ADC conversion done sets bank 1 bit 0; software clears it.
// RULE_11 - voltage detect event sets bank 2 bit 7.
// RULE_12 - any zero-cross output change sets bank 2 bit 6.
// RULE_13 - comparator 1 or 2 output change sets bank 2 bit 0 or 1.
// RULE_14 - bank 3 bit 5 read-only, high while receive buffer holds data.
// RULE_15 - bank 3 bit 4 read-only, high while transmit buffer is empty.
// RULE_16 - master-mode bus collision sets bank 3 bit 1; software clears it.
// RULE_17 - sync serial transfer done sets bank 3 bit 0 until cleared.
// RULE_18 - timer six period match sets bank 4 bit 5.
// RULE_19 - timer five overflow sets bank 4 bit 4.
// RULE_20 - timer four period match sets bank 4 bit 3.
// RULE_21 - flags set regardless of any enable bit, allowing polling.
// RULE_22 - software clears flags before enabling the matching interrupt.
// RULE_23 - unimplemented flag bits read zero, writes to them ignored.
// RULE_24 - a hardware set beats a software clear in the same cycle.
`ifndef PIFB_DEFS_SVH
`define PIFB_DEFS_SVH

`define PIFB_EXT_PINS     8
`define PIFB_PSEL_W       3
`define PIFB_PC_W         8
`define PIFB_IDX_W        12
`define PIFB_ADDR_TOP     14

// word indices; byte address is four times the index
`define PIFB_IDX_BANK0    12'hec5
`define PIFB_IDX_BANK1    12'hec6
`define PIFB_IDX_BANK2    12'hec7
`define PIFB_IDX_BANK3    12'hec8
`define PIFB_IDX_BANK4    12'hec9
`define PIFB_IDX_CTRL     12'hed0
`define PIFB_IDX_PSEL     12'hed1
`define PIFB_IDX_PCF      12'hed2

// software-writable bits per bank
`define PIFB_RW_BANK0     8'h27
`define PIFB_RW_BANK1     8'hc3
`define PIFB_RW_BANK2     8'hc3
`define PIFB_RW_BANK3     8'h03
`define PIFB_RW_BANK4     8'h38
`define PIFB_MASK_NOCSW   8'hbf

`define PIFB_B0_TMR0      5
`define PIFB_B0_PCSUM     4
`define PIFB_B1_CSW       6
`define PIFB_B3_RX        5
`define PIFB_B3_TX        4
`define PIFB_CTRL_GIE     7
`define PIFB_CTRL_PERIPHERAL_IRQ_GATE    6

`define PIFB_RST_FLAGS    8'h00
`define PIFB_RST_EDGE     3'h7
`define PIFB_RST_PSEL     9'h000

`define PIFB_HTRANS_IDLE  2'h0
`define PIFB_HRESP_OKAY   1'h0

`endif

// ### design/pifb_pkg.sv
`include "pifb_defs.svh"

package pifb_pkg;

   typedef struct packed {
      logic [7:0]                       bank0;
      logic [7:0]                       bank1;
      logic [7:0]                       bank2;
      logic [7:0]                       bank3;
      logic [7:0]                       bank4;
      logic [`PIFB_PC_W-1:0]            per_pin_change_flags;
      logic                             gie;
      logic                             peripheral_irq_gate;
      logic [2:0]                       edge_sel;
      logic [3*`PIFB_PSEL_W-1:0]        ext_irq_pin_select;
      logic [`PIFB_EXT_PINS-1:0]        sync1;
      logic [`PIFB_EXT_PINS-1:0]        sync2;
      logic [`PIFB_EXT_PINS-1:0]        sync3;
      logic [`PIFB_EXT_PINS-1:0]        pin_level;
      logic [2:0]                       ext_prev;
      logic                             zcd_prev;
      logic [1:0]                       cmp_prev;
      logic                             pend_wr;
      logic                             pend_ok;
      logic [`PIFB_IDX_W-1:0]           pend_idx;
      logic [31:0]                      rdata;
      logic                             irq;
      logic                             wake;
   } pifb_state_t;

endpackage

// ### design/pifb_flag_bank.sv
`timescale 1ns/10ps
`include "pifb_defs.svh"

module pifb_flag_bank
   import pifb_pkg::*;
(
   input  wire logic                        ref_clk,
   input  wire logic                        sys_rst,
   input  wire logic                        hsel,
   input  wire logic [31:0]                 haddr,
   input  wire logic [1:0]                  htrans,
   input  wire logic                        hwrite,
   input  wire logic [2:0]                  hsize,
   input  wire logic [31:0]                 hwdata,
   input  wire logic                        hready,
   output logic                             hreadyout,
   output logic                             hresp,
   output logic [31:0]                      hrdata,
   input  wire logic [`PIFB_EXT_PINS-1:0]   ext_pins,
   input  wire logic [`PIFB_PC_W-1:0]       pin_change_event,
   input  wire logic                        timer_zero_overflow,
   input  wire logic                        osc_fail,
   input  wire logic                        clock_switch_ready,
   input  wire logic                        adc_threshold,
   input  wire logic                        adc_done,
   input  wire logic                        voltage_detect,
   input  wire logic                        zero_cross_out,
   input  wire logic [1:0]                  comparator_out,
   input  wire logic                        uart_rx_full,
   input  wire logic                        uart_tx_empty,
   input  wire logic                        bus_collision,
   input  wire logic                        sync_serial_done,
   input  wire logic                        timer_four_match,
   input  wire logic                        timer_five_overflow,
   input  wire logic                        timer_six_match,
   input  wire logic [7:0]                  irq_en_bank0,
   input  wire logic [7:0]                  irq_en_bank1,
   input  wire logic [7:0]                  irq_en_bank2,
   input  wire logic [7:0]                  irq_en_bank3,
   input  wire logic [7:0]                  irq_en_bank4,
   output logic                             core_irq,
   output logic                             sleep_wake
);

   pifb_state_t st;
   pifb_state_t next_st;

   // software write first, hardware set after, so a set always survives
   function automatic logic [7:0] flag_next(input logic [7:0] cur,
                                            input logic       we,
                                            input logic [7:0] wd,
                                            input logic [7:0] rw,
                                            input logic [7:0] set);
      logic [7:0] v;
      v = we ? ((wd & rw) | (cur & ~rw)) : cur;
      return (v | set) & rw;
   endfunction

   function automatic logic idx_hit(input logic                   ok,
                                    input logic [`PIFB_IDX_W-1:0] idx,
                                    input logic [`PIFB_IDX_W-1:0] reg_idx);
      return ok && (idx == reg_idx);
   endfunction

   logic                         take;
   logic                         addr_ok;
   logic [`PIFB_IDX_W-1:0]       addr_idx;
   logic                         wr_now;
   logic [7:0]                   wd;
   logic [2:0]                   ext_lvl;
   logic [2:0]                   ext_hit;
   logic                         zcd_chg;
   logic [1:0]                   cmp_chg;
   logic [7:0]                   set0;
   logic [7:0]                   set1;
   logic [7:0]                   set2;
   logic [7:0]                   set3;
   logic [7:0]                   set4;
   logic                         bank0_req;
   logic                         periph_req;

   assign hreadyout = 1'b1;
   assign hresp     = `PIFB_HRESP_OKAY;
   assign hrdata    = st.rdata;
   assign core_irq  = st.irq;
   assign sleep_wake = st.wake;

   always_comb begin
      next_st  = st;
      take     = hsel && htrans[1] && hready;
      addr_ok  = (haddr[31:`PIFB_ADDR_TOP] == '0) && (haddr[1:0] == 2'h0);
      addr_idx = haddr[`PIFB_ADDR_TOP-1:2];
      wr_now   = st.pend_wr && st.pend_ok;
      wd       = hwdata[7:0];

      // three-stage sampling; a pin counts once stages two and three agree
      next_st.sync1 = ext_pins;
      next_st.sync2 = st.sync1;
      next_st.sync3 = st.sync2;
      for (int i = 0; i < `PIFB_EXT_PINS; i++) begin
         if (st.sync2[i] == st.sync3[i]) begin
            next_st.pin_level[i] = st.sync3[i];
         end
      end

      for (int x = 0; x < 3; x++) begin
         ext_lvl[x] = st.pin_level[st.ext_irq_pin_select
                      [x*`PIFB_PSEL_W +: `PIFB_PSEL_W]]; // RULE_05
         ext_hit[x] = st.edge_sel[x] ? (ext_lvl[x] && !st.ext_prev[x])
                                     : (!ext_lvl[x] && st.ext_prev[x]); // RULE_03
      end
      next_st.ext_prev = ext_lvl;

      zcd_chg          = zero_cross_out != st.zcd_prev; // RULE_12
      cmp_chg          = comparator_out ^ st.cmp_prev; // RULE_13
      next_st.zcd_prev = zero_cross_out;
      next_st.cmp_prev = comparator_out;

      // sets ignore every enable so software may poll
      set0 = {2'h0, timer_zero_overflow, 2'h0, ext_hit}; // RULE_01 RULE_21
      set1 = {osc_fail, clock_switch_ready, 4'h0,
              adc_threshold, adc_done}; // RULE_06 RULE_07 RULE_09 RULE_10
      set2 = {voltage_detect, zcd_chg, 4'h0, cmp_chg}; // RULE_11
      set3 = {6'h00, bus_collision, sync_serial_done}; // RULE_16 RULE_17
      set4 = {2'h0, timer_six_match, timer_five_overflow,
              timer_four_match, 3'h0}; // RULE_18 RULE_19 RULE_20

      next_st.per_pin_change_flags = (idx_hit(wr_now, st.pend_idx,
            `PIFB_IDX_PCF) ? wd[`PIFB_PC_W-1:0] : st.per_pin_change_flags)
            | pin_change_event; // RULE_24

      next_st.bank0 = flag_next(st.bank0,
            idx_hit(wr_now, st.pend_idx, `PIFB_IDX_BANK0), wd,
            `PIFB_RW_BANK0, set0); // RULE_23 RULE_24
      next_st.bank0[`PIFB_B0_PCSUM] = |next_st.per_pin_change_flags; // RULE_02
      next_st.bank1 = flag_next(st.bank1,
            idx_hit(wr_now, st.pend_idx, `PIFB_IDX_BANK1), wd,
            `PIFB_RW_BANK1, set1); // RULE_24
      next_st.bank2 = flag_next(st.bank2,
            idx_hit(wr_now, st.pend_idx, `PIFB_IDX_BANK2), wd,
            `PIFB_RW_BANK2, set2); // RULE_24
      next_st.bank3 = flag_next(st.bank3,
            idx_hit(wr_now, st.pend_idx, `PIFB_IDX_BANK3), wd,
            `PIFB_RW_BANK3, set3); // RULE_24
      // the buffer flags mirror the serial port; its own read or write clears
      next_st.bank3[`PIFB_B3_RX] = uart_rx_full; // RULE_14
      next_st.bank3[`PIFB_B3_TX] = uart_tx_empty; // RULE_15
      next_st.bank4 = flag_next(st.bank4,
            idx_hit(wr_now, st.pend_idx, `PIFB_IDX_BANK4), wd,
            `PIFB_RW_BANK4, set4); // RULE_24

      if (idx_hit(wr_now, st.pend_idx, `PIFB_IDX_CTRL)) begin
         next_st.gie                 = wd[`PIFB_CTRL_GIE];
         next_st.peripheral_irq_gate = wd[`PIFB_CTRL_PERIPHERAL_IRQ_GATE];
         next_st.edge_sel            = wd[2:0];
      end
      if (idx_hit(wr_now, st.pend_idx, `PIFB_IDX_PSEL)) begin
         next_st.ext_irq_pin_select = hwdata[3*`PIFB_PSEL_W-1:0]; // RULE_05
      end

      bank0_req  = |(next_st.bank0 & irq_en_bank0);
      periph_req = |(next_st.bank1 & irq_en_bank1)
                 | |(next_st.bank2 & irq_en_bank2)
                 | |(next_st.bank3 & irq_en_bank3)
                 | |(next_st.bank4 & irq_en_bank4);
      // bank 0 requests do not pass through the peripheral gate
      next_st.irq = next_st.gie && (bank0_req ||
                    (next_st.peripheral_irq_gate && periph_req)); // RULE_04
      // wake ignores the global enable, but never for the clock-switch flag
      next_st.wake = bank0_req
                   | |(next_st.bank1 & irq_en_bank1 & `PIFB_MASK_NOCSW)
                   | |(next_st.bank2 & irq_en_bank2)
                   | |(next_st.bank3 & irq_en_bank3)
                   | |(next_st.bank4 & irq_en_bank4); // RULE_08

      // reads return the value as it stands after this edge, so a write
      // in its data phase is seen by a read issued in the same cycle
      if (take && !hwrite) begin
         next_st.rdata = 32'h0000_0000;
         if (addr_ok) begin
            unique case (addr_idx)
               `PIFB_IDX_BANK0: next_st.rdata[7:0] = next_st.bank0;
               `PIFB_IDX_BANK1: next_st.rdata[7:0] = next_st.bank1;
               `PIFB_IDX_BANK2: next_st.rdata[7:0] = next_st.bank2;
               `PIFB_IDX_BANK3: next_st.rdata[7:0] = next_st.bank3;
               `PIFB_IDX_BANK4: next_st.rdata[7:0] = next_st.bank4;
               `PIFB_IDX_CTRL: next_st.rdata[7:0] = {next_st.gie,
                     next_st.peripheral_irq_gate, 3'h0, next_st.edge_sel};
               `PIFB_IDX_PSEL: next_st.rdata[3*`PIFB_PSEL_W-1:0] =
                     next_st.ext_irq_pin_select;
               `PIFB_IDX_PCF: next_st.rdata[`PIFB_PC_W-1:0] =
                     next_st.per_pin_change_flags;
               default: next_st.rdata = 32'h0000_0000;
            endcase
         end
      end

      next_st.pend_wr  = take && hwrite;
      next_st.pend_ok  = take && addr_ok;
      next_st.pend_idx = take ? addr_idx : st.pend_idx;
   end

   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         st                     <= '0;
         st.bank0               <= `PIFB_RST_FLAGS;
         st.bank1               <= `PIFB_RST_FLAGS;
         st.bank2               <= `PIFB_RST_FLAGS;
         st.bank3               <= `PIFB_RST_FLAGS;
         st.bank4               <= `PIFB_RST_FLAGS;
         st.edge_sel            <= `PIFB_RST_EDGE;
         st.ext_irq_pin_select  <= `PIFB_RST_PSEL;
      end else begin
         st <= next_st;
      end
   end

   // checks look at registered state, one edge after the cause
   default clocking dcb @(posedge ref_clk);
   endclocking
   default disable iff (sys_rst);

   sequence s_wr_zero_bank4;
      wr_now && (st.pend_idx == `PIFB_IDX_BANK4) && (wd == 8'h00);
   endsequence

   sequence s_pin0_rise_held;
      !st.sync1[0] && ext_pins[0] ##1 ext_pins[0] [*4];
   endsequence

   sequence s_pcf_all_cleared;
      wr_now && (st.pend_idx == `PIFB_IDX_PCF) && (wd == 8'h00)
         && (pin_change_event == '0);
   endsequence

   a_tmr0_sets: assert property ( // RULE_01
      timer_zero_overflow |=> st.bank0[`PIFB_B0_TMR0])
      else $error("timer zero flag not set after overflow");

   a_pcsum_tracks: assert property ( // RULE_02
      s_pcf_all_cleared |=> !st.bank0[`PIFB_B0_PCSUM] ##0
                           (st.per_pin_change_flags == '0))
      else $error("pin-change summary still high after all cleared");

   a_pcsum_sets: assert property ( // RULE_02
      (pin_change_event != '0) |=> st.bank0[`PIFB_B0_PCSUM])
      else $error("pin-change summary missed an event");

   a_ext_edge: assert property ( // RULE_03
      (st.ext_irq_pin_select[`PIFB_PSEL_W-1:0] == '0) && st.edge_sel[0]
         && !st.pin_level[0] ##0 s_pin0_rise_held
         |-> ##[0:2] st.bank0[0])
      else $error("external input 0 rising edge not flagged");

   a_bank0_gate: assert property ( // RULE_04
      st.gie && !st.peripheral_irq_gate
         && ((st.bank0 & irq_en_bank0) != 8'h00)
         ##1 ((st.bank0 & irq_en_bank0) != 8'h00) |-> core_irq)
      else $error("bank 0 request blocked by peripheral gate");

   a_periph_gate: assert property ( // RULE_04
      !st.peripheral_irq_gate && ((st.bank0 & irq_en_bank0) == 8'h00)
         && $stable(st.bank0) && $stable(st.peripheral_irq_gate)
         |-> !core_irq)
      else $error("peripheral request passed a closed gate");

   a_csw_nowake: assert property ( // RULE_08
      ((st.bank0 & irq_en_bank0) == 8'h00)
         && ((st.bank1 & irq_en_bank1 & `PIFB_MASK_NOCSW) == 8'h00)
         && ((st.bank2 & irq_en_bank2) == 8'h00)
         && ((st.bank3 & irq_en_bank3) == 8'h00)
         && ((st.bank4 & irq_en_bank4) == 8'h00)
         |-> !sleep_wake)
      else $error("wake raised by clock-switch flag alone");

   a_zcd_change: assert property ( // RULE_12
      $changed(zero_cross_out) |=> st.bank2[6])
      else $error("zero-cross change not flagged");

   a_cmp_change: assert property ( // RULE_13
      $changed(comparator_out[1]) |=> st.bank2[1])
      else $error("comparator 2 change not flagged");

   a_rx_mirror: assert property ( // RULE_14
      uart_rx_full |=> st.bank3[`PIFB_B3_RX])
      else $error("receive flag does not follow buffer state");

   a_tx_mirror: assert property ( // RULE_15
      $fell(uart_tx_empty) |=> !st.bank3[`PIFB_B3_TX])
      else $error("transmit empty flag not cleared by buffer write");

   a_set_wins: assert property ( // RULE_24
      s_wr_zero_bank4 ##0 (timer_five_overflow && !timer_six_match)
         |=> st.bank4[4] && !st.bank4[5])
      else $error("hardware set lost to software clear");

   a_unimpl_zero: assert property ( // RULE_23
      ((st.bank1 & ~`PIFB_RW_BANK1) == 8'h00)
         && ((st.bank4 & ~`PIFB_RW_BANK4) == 8'h00)
         && ((st.bank2 & ~`PIFB_RW_BANK2) == 8'h00))
      else $error("unimplemented flag bit is set");

   a_adc_poll: assert property ( // RULE_21
      adc_done && (irq_en_bank1 == 8'h00) |=> st.bank1[0] && (!core_irq
         || st.gie))
      else $error("adc done flag not set while disabled");

   a_tmr0_holds: assert property ( // RULE_01
      st.bank0[`PIFB_B0_TMR0]
         && !idx_hit(wr_now, st.pend_idx, `PIFB_IDX_BANK0)
         |=> st.bank0[`PIFB_B0_TMR0])
      else $error("timer zero flag lost");

   a_osc_fail: assert property ( // RULE_06
      osc_fail |=> st.bank1[7])
      else $error("oscillator fail not flagged");

   a_csw_sets: assert property ( // RULE_07
      clock_switch_ready |=> st.bank1[6])
      else $error("clock switch ready not flagged");

   a_adc_thresh: assert property ( // RULE_09
      adc_threshold |=> st.bank1[1])
      else $error("adc threshold not flagged");

   a_adc_done: assert property ( // RULE_10
      adc_done |=> st.bank1[0])
      else $error("adc done not flagged");

   a_wake_adc: assert property ( // RULE_21
      adc_done && irq_en_bank1[0] |=> sleep_wake)
      else $error("enabled adc flag did not wake");

   a_volt_sets: assert property ( // RULE_11
      voltage_detect |=> st.bank2[7])
      else $error("voltage detect not flagged");

   a_cmp1_change: assert property ( // RULE_13
      $changed(comparator_out[0]) |=> st.bank2[0])
      else $error("comparator 1 change not flagged");

   a_rx_clear: assert property ( // RULE_14
      !uart_rx_full |=> !st.bank3[`PIFB_B3_RX])
      else $error("receive flag high with buffer empty");

   a_tx_sets: assert property ( // RULE_15
      uart_tx_empty |=> st.bank3[`PIFB_B3_TX])
      else $error("transmit empty flag not set");

   a_bcl_sets: assert property ( // RULE_16
      bus_collision |=> st.bank3[1])
      else $error("bus collision not flagged");

   a_ssp_sets: assert property ( // RULE_17
      sync_serial_done |=> st.bank3[0])
      else $error("serial done not flagged");

   a_tmr6_sets: assert property ( // RULE_18
      timer_six_match |=> st.bank4[5])
      else $error("timer six match not flagged");

   a_tmr5_sets: assert property ( // RULE_19
      timer_five_overflow |=> st.bank4[4])
      else $error("timer five overflow not flagged");

   a_tmr4_sets: assert property ( // RULE_20
      timer_four_match |=> st.bank4[3])
      else $error("timer four match not flagged");

endmodule // pifb_flag_bank

// ### verification/pifb_event_model.sv
`timescale 1ns/10ps
module pifb_event_model (
   input  wire logic        ref_clk,
   input  wire logic        sys_rst,
   input  wire logic [13:0] fire,
   output logic             timer_zero_overflow,
   output logic             osc_fail,
   output logic             clock_switch_ready,
   output logic             adc_threshold,
   output logic             adc_done,
   output logic             voltage_detect,
   output logic             bus_collision,
   output logic             sync_serial_done,
   output logic             timer_four_match,
   output logic             timer_five_overflow,
   output logic             timer_six_match,
   output logic             zero_cross_out,
   output logic [1:0]       comparator_out
);
   assign timer_zero_overflow = fire[0];
   assign osc_fail            = fire[1];
   assign clock_switch_ready  = fire[2];
   assign adc_threshold       = fire[3];
   assign adc_done            = fire[4];
   assign voltage_detect      = fire[5];
   assign bus_collision       = fire[6];
   assign sync_serial_done    = fire[7];
   assign timer_four_match    = fire[8];
   assign timer_five_overflow = fire[9];
   assign timer_six_match     = fire[10];
   // analog outputs are levels: a request flips them instead of pulsing
   always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
         zero_cross_out <= 1'b0;
         comparator_out <= 2'h0;
      end else begin
         zero_cross_out <= zero_cross_out ^ fire[11];
         comparator_out <= comparator_out ^ fire[13:12];
      end
   end
endmodule // pifb_event_model

// ### verification/tb_peripheral_irq_flag_bank.sv
`timescale 1ns/10ps
module tb_peripheral_irq_flag_bank;
   logic        ref_clk = 1'b0;
   logic        sys_rst = 1'b1;
   logic        hsel = 1'b0;
   logic        hwrite = 1'b0;
   logic [1:0]  htrans = 2'h0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [13:0] fire = 14'h0;
   logic [7:0]  ext_pins = 8'h0;
   logic [7:0]  pin_change_event = 8'h0;
   logic        uart_rx_full = 1'b0;
   logic        uart_tx_empty = 1'b0;
   logic [7:0]  en0 = 8'h0;
   logic [7:0]  en1 = 8'h0;
   logic        hreadyout, hresp, core_irq, sleep_wake;
   logic [31:0] hrdata;
   logic        t0, ofl, csw, athr, adn, vd, bcl, ssp, t4, t5, t6, zc;
   logic [1:0]  cmp;
   int          failures = 0;
   int          comparisons = 0;
   localparam int ev_bank[14] = '{0, 1, 1, 1, 1, 2, 3, 3, 4, 4, 4, 2, 2, 2};
   localparam int ev_bit[14] = '{5, 7, 6, 1, 0, 7, 1, 0, 3, 4, 5, 6, 0, 1};
   localparam logic [7:0] rw_mask[5] = '{8'h27, 8'hc3, 8'hc3, 8'h03, 8'h38};
   localparam logic [31:0] ctrl_a = 32'h3b40;
   localparam logic [31:0] psel_a = 32'h3b44;
   localparam logic [31:0] pcf_a = 32'h3b48;

   always #4 ref_clk = ~ref_clk;

   pifb_event_model i_pifb_event_model (.ref_clk(ref_clk), .sys_rst(sys_rst),
      .fire(fire), .timer_zero_overflow(t0), .osc_fail(ofl),
      .clock_switch_ready(csw), .adc_threshold(athr), .adc_done(adn),
      .voltage_detect(vd), .bus_collision(bcl), .sync_serial_done(ssp),
      .timer_four_match(t4), .timer_five_overflow(t5), .timer_six_match(t6),
      .zero_cross_out(zc), .comparator_out(cmp));

   pifb_flag_bank i_pifb_flag_bank (.ref_clk(ref_clk), .sys_rst(sys_rst),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .ext_pins(ext_pins), .pin_change_event(pin_change_event),
      .timer_zero_overflow(t0), .osc_fail(ofl), .clock_switch_ready(csw),
      .adc_threshold(athr), .adc_done(adn), .voltage_detect(vd),
      .zero_cross_out(zc), .comparator_out(cmp), .uart_rx_full(uart_rx_full),
      .uart_tx_empty(uart_tx_empty), .bus_collision(bcl),
      .sync_serial_done(ssp), .timer_four_match(t4),
      .timer_five_overflow(t5), .timer_six_match(t6), .irq_en_bank0(en0),
      .irq_en_bank1(en1), .irq_en_bank2(8'h0), .irq_en_bank3(8'h0),
      .irq_en_bank4(8'h0), .core_irq(core_irq), .sleep_wake(sleep_wake));

   function automatic logic [31:0] bank_a(input int b);
      return 32'h3b14 + 32'(4 * b);
   endfunction

   task automatic end_of_test;
      $display("comparisons=%0d failures=%0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         failures++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wait_rdy;
      int n;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (hreadyout !== 1'b1 && n < 64);
      if (hreadyout !== 1'b1) begin
         failures++;
         end_of_test();
      end
   endtask

   // f raises event requests during the data phase, to meet a write there
   task automatic bus(input logic w, input logic [31:0] a,
                      input logic [31:0] d, input logic [13:0] f,
                      output logic [31:0] q);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      wait_rdy();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      if (f != 14'h0) fire <= f;
      wait_rdy();
      if (f != 14'h0) fire <= 14'h0;
      q = hrdata;
   endtask

   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, 14'h0, q);
   endtask

   task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, 14'h0, q);
      chk(q, exp);
   endtask

   task automatic ev(input int n);
      fire <= 14'h1 << n;
      @(posedge ref_clk);
      fire <= 14'h0;
      repeat (3) @(posedge ref_clk);
   endtask

   task automatic t_reset;
      for (int b = 0; b < 5; b++) rd_chk(bank_a(b), 32'h0);
      rd_chk(ctrl_a, 32'h7);
   endtask

   task automatic t_events;
      for (int i = 0; i < 14; i++) begin
         ev(i);
         rd_chk(bank_a(ev_bank[i]), 32'h1 << ev_bit[i]);
         wr(bank_a(ev_bank[i]), 32'h0);
         rd_chk(bank_a(ev_bank[i]), 32'h0);
      end
   endtask

   task automatic t_masks;
      for (int b = 0; b < 5; b++) begin
         wr(bank_a(b), 32'hffffffff);
         rd_chk(bank_a(b), {24'h0, rw_mask[b]});
         wr(bank_a(b), 32'h0);
      end
      wr(32'h3b28, 32'hff);
      rd_chk(32'h3b28, 32'h0);
      chk(32'(hresp), 32'h0);
   endtask

   task automatic t_uart;
      uart_rx_full <= 1'b1;
      repeat (3) @(posedge ref_clk);
      wr(bank_a(3), 32'h0);
      rd_chk(bank_a(3), 32'h20);
      uart_rx_full <= 1'b0;
      uart_tx_empty <= 1'b1;
      repeat (3) @(posedge ref_clk);
      rd_chk(bank_a(3), 32'h10);
      uart_tx_empty <= 1'b0;
      repeat (3) @(posedge ref_clk);
      rd_chk(bank_a(3), 32'h0);
   endtask

   task automatic t_pin_change;
      pin_change_event <= 8'h08;
      @(posedge ref_clk);
      pin_change_event <= 8'h0;
      repeat (3) @(posedge ref_clk);
      wr(bank_a(0), 32'h0);
      rd_chk(bank_a(0), 32'h10);
      rd_chk(pcf_a, 32'h08);
      wr(pcf_a, 32'h0);
      rd_chk(bank_a(0), 32'h0);
   endtask

   task automatic t_ext;
      ext_pins <= 8'h01;
      repeat (10) @(posedge ref_clk);
      rd_chk(bank_a(0), 32'h07);
      wr(bank_a(0), 32'h0);
      // input 0 from pin 5, inputs 1 and 2 from pins 6 and 7
      wr(psel_a, 32'h1f5);
      ext_pins <= 8'h01;
      repeat (10) @(posedge ref_clk);
      rd_chk(bank_a(0), 32'h0);
      ext_pins <= 8'h21;
      repeat (10) @(posedge ref_clk);
      rd_chk(bank_a(0), 32'h01);
      wr(bank_a(0), 32'h0);
      wr(ctrl_a, 32'h06);
      ext_pins <= 8'h0;
      repeat (10) @(posedge ref_clk);
      rd_chk(bank_a(0), 32'h01);
      wr(bank_a(0), 32'h0);
   endtask

   task automatic t_irq;
      wr(bank_a(1), 32'h0);
      wr(ctrl_a, 32'h80);
      en1 <= 8'h01;
      ev(4);
      chk(32'(core_irq), 32'h0);
      chk(32'(sleep_wake), 32'h1);
      wr(bank_a(0), 32'h0);
      en0 <= 8'h20;
      ev(0);
      chk(32'(core_irq), 32'h1);
      wr(bank_a(0), 32'h0);
      wr(bank_a(1), 32'h0);
      en0 <= 8'h0;
      en1 <= 8'h40;
      ev(2);
      chk(32'(sleep_wake), 32'h0);
      wr(ctrl_a, 32'hc0);
      repeat (3) @(posedge ref_clk);
      chk(32'(core_irq), 32'h1);
      wr(bank_a(1), 32'h0);
      en1 <= 8'h0;
   endtask

   task automatic t_collide;
      logic [31:0] q;
      ev(10);
      bus(1'b1, bank_a(4), 32'h0, 14'h200, q);
      rd_chk(bank_a(4), 32'h10);
      wr(bank_a(4), 32'h0);
      rd_chk(bank_a(4), 32'h0);
   endtask

   initial begin
      repeat (10) @(posedge ref_clk);
      sys_rst <= 1'b0;
      @(posedge ref_clk);
      t_reset();
      t_events();
      t_masks();
      t_uart();
      t_pin_change();
      t_ext();
      t_irq();
      t_collide();
      end_of_test();
   end
endmodule // tb_peripheral_irq_flag_bank
